// ===== logic/ocd_map.svh
`ifndef OCD_MAP_SVH
`define OCD_MAP_SVH

// ---------------------------------------------
// Opcodes outside the subtract groups
// ---------------------------------------------
`define OCD_OP_PREFIX      8'h18
`define OCD_OP_TEST        8'h00
`define OCD_OP_FLAGS_FROM_A 8'h06
`define OCD_OP_FLAGS_TO_A  8'h07
`define OCD_OP_COPY_A_B    8'h16
`define OCD_OP_COPY_B_A    8'h17
`define OCD_OP_SP_TO_IDX   8'h30
`define OCD_OP_IDX_TO_SP   8'h35
`define OCD_OP_SLEEP       8'h3e
`define OCD_OP_TRAP        8'h3f
`define OCD_OP_ZCMP_A      8'h4d
`define OCD_OP_ZCMP_B      8'h5d
`define OCD_OP_ZCMP_IND    8'h6d
`define OCD_OP_ZCMP_EXT    8'h7d
`define OCD_OP_SWAP_D      8'h8f

// ---------------------------------------------
// Cycle counts, opcode fetch included
// ---------------------------------------------
`define OCD_CYC_INH        5'd2
`define OCD_CYC_XFER       5'd3
`define OCD_CYC_IMM        5'd2
`define OCD_CYC_DIR        5'd3
`define OCD_CYC_EXT_IND    5'd4
`define OCD_CYC_WORD_EXTRA 5'd2
`define OCD_CYC_ZCMP_MEM   5'd6
`define OCD_CYC_PREFIX     5'd1
`define OCD_PUSH_LAST      4'h8

// ---------------------------------------------
// Flag bit positions and reset values
// ---------------------------------------------
`define OCD_F_X            6
`define OCD_F_I            4
`define OCD_F_N            3
`define OCD_F_Z            2
`define OCD_F_V            1
`define OCD_F_C            0
`define OCD_RST_FLAGS      8'hd0
`define OCD_RST_PC         16'h0000
`define OCD_RST_SP         16'h0000
`define OCD_VEC_TRAP       16'hff00
`define OCD_IDLE_ADDR      16'hffff

`endif

// ===== logic/ocd_pkg.sv
`default_nettype none

package ocd_pkg;

   typedef enum logic [3:0] {
      st_fetch    = 4'b0000,
      st_prefix   = 4'b0001,
      st_operand  = 4'b0010,
      st_calc     = 4'b0011,
      st_data     = 4'b0100,
      st_pad      = 4'b0101,
      st_stk_pre  = 4'b0110,
      st_stack    = 4'b0111,
      st_stk_post = 4'b1000,
      st_sleep    = 4'b1001,
      st_vector   = 4'b1010,
      st_testrun  = 4'b1011
   } ocd_st_t;

   // Subtract-group modes follow opcode bits 5:4
   typedef enum logic [2:0] {
      m_imm = 3'b000,
      m_dir = 3'b001,
      m_ind = 3'b010,
      m_ext = 3'b011,
      m_inh = 3'b100
   } ocd_mode_t;

   typedef enum logic [4:0] {
      k_illegal    = 5'b00000,
      k_sub_a      = 5'b00001,
      k_sub_b      = 5'b00010,
      k_sub_d      = 5'b00011,
      k_zcmp_mem   = 5'b00100,
      k_zcmp_a     = 5'b00101,
      k_zcmp_b     = 5'b00110,
      k_flags_in   = 5'b00111,
      k_flags_out  = 5'b01000,
      k_copy_a_b   = 5'b01001,
      k_copy_b_a   = 5'b01010,
      k_sp_to_idx  = 5'b01011,
      k_idx_to_sp  = 5'b01100,
      k_swap_d     = 5'b01101,
      k_soft_trap  = 5'b01110,
      k_sleep      = 5'b01111,
      k_test_run   = 5'b10000
   } ocd_kind_t;

   typedef struct packed {
      ocd_kind_t kind;
      ocd_mode_t mode;
      logic [4:0] total;
   } ocd_dec_t;

   typedef struct packed {
      ocd_st_t     st;
      logic [4:0]  cyc;
      logic [3:0]  cnt;
      logic [7:0]  op;
      logic        pfx;
      logic [15:0] pc;
      logic [15:0] sp;
      logic [15:0] ix;
      logic [15:0] iy;
      logic [15:0] ea;
      logic [15:0] opw;
      logic [15:0] addr;
      logic [7:0]  a;
      logic [7:0]  b;
      logic [7:0]  flag_register;
      logic [7:0]  wdata;
      logic        rw;
      logic        ill;
      logic        wt;
      logic        vsel;
   } ocd_state_t;

endpackage

`default_nettype wire

// ===== logic/ocd_core.sv
// Function
// - Subtract memory byte from A, four modes plus Y-indexed, 2 to 5 cycles.
// - Subtract memory byte from B, same modes and cycle counts as A.
// - Subtract 16-bit word from D, 4 to 7 cycles, update N Z V C.
// - Opcode 06 loads all flags from A in 2 cycles.
// - Loading flags from A may clear the X mask, never set it.
// - Opcode 07 copies flags into A in 2 cycles, flags untouched.
// - Opcode 00 in test mode increments address bus until reset.
// - Memory byte compared with zero, 6/6/7 cycles, N Z set, V C cleared.
// - Opcodes 4D and 5D compare A or B with zero in 2 cycles.
// - Opcode 30 loads index X with SP plus one in 3 cycles.
// - Opcode 18 30 loads index Y with SP plus one in 4 cycles.
// - Opcode 35 loads SP with index X minus one in 3 cycles.
// - Opcode 18 35 loads SP with index Y minus one in 4 cycles.
// - Sleep opcode stacks in 12 cycles, idles n, fetches vector: 14+n.
// - Direct operand byte is the address low half, high half zero.
// - Indexed operand is unsigned byte added to selected index register.
// - Sixteen-bit immediate fetched high byte first, then low byte.
// - Extended address fetched high byte first, then low byte.
`default_nettype none
`include "ocd_map.svh"

module ocd_core
   import ocd_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  data_i,
   input  wire logic        irq_i,
   input  wire logic        xirq_i,
   input  wire logic        test_mode_i,
   input  wire logic [15:0] irq_vec_i,
   output var  logic [15:0] addr_o,
   output var  logic        rw_o,
   output var  logic [7:0]  wdata_o,
   output var  logic [7:0]  acc_a_o,
   output var  logic [7:0]  acc_b_o,
   output var  logic [15:0] index_x_o,
   output var  logic [15:0] index_y_o,
   output var  logic [15:0] sp_o,
   output var  logic [15:0] pc_o,
   output var  logic [7:0]  flag_register_o,
   output var  logic        illegal_op_o,
   output var  logic        sleeping_o
);
   import ocd_pkg::*;

   localparam ocd_state_t RST_STATE = '{st: st_fetch, pc: `OCD_RST_PC, sp: `OCD_RST_SP,
                                        addr: `OCD_RST_PC, flag_register: `OCD_RST_FLAGS, rw: 1'b1,
                                        default: '0};

   ocd_state_t  q;
   ocd_state_t  d;
   ocd_dec_t    dc;
   logic        go;
   logic        fin;
   logic        wake;
   logic [15:0] idx;
   logic [7:0]  lhs8;
   logic [8:0]  dif9;
   logic [16:0] dif17;

   // ---------------------------------------------
   // Opcode decode
   // ---------------------------------------------
   function automatic ocd_dec_t ocd_decode(input logic [7:0] op, input logic pfx);
      ocd_dec_t r;
      r.kind  = k_illegal;
      r.mode  = m_inh;
      r.total = `OCD_CYC_INH;
      if (op[7] && op[3:0] == 4'h0) begin
         r.kind = op[6] ? k_sub_b : k_sub_a;
         r.mode = ocd_mode_t'({1'b0, op[5:4]});
      end else if (op[7:6] == 2'b10 && op[3:0] == 4'h3) begin
         r.kind = k_sub_d;
         r.mode = ocd_mode_t'({1'b0, op[5:4]});
      end else begin
         case (op)
            `OCD_OP_TEST:         r.kind = k_test_run;
            `OCD_OP_FLAGS_FROM_A: r.kind = k_flags_in;
            `OCD_OP_FLAGS_TO_A:   r.kind = k_flags_out;
            `OCD_OP_COPY_A_B:     r.kind = k_copy_a_b;
            `OCD_OP_COPY_B_A:     r.kind = k_copy_b_a;
            `OCD_OP_ZCMP_A:       r.kind = k_zcmp_a;
            `OCD_OP_ZCMP_B:       r.kind = k_zcmp_b;
            `OCD_OP_SP_TO_IDX:    r.kind = k_sp_to_idx;
            `OCD_OP_IDX_TO_SP:    r.kind = k_idx_to_sp;
            `OCD_OP_SWAP_D:       r.kind = k_swap_d;
            `OCD_OP_TRAP:         r.kind = k_soft_trap;
            `OCD_OP_SLEEP:        r.kind = k_sleep;
            `OCD_OP_ZCMP_IND,
            `OCD_OP_ZCMP_EXT: begin
               r.kind = k_zcmp_mem;
               r.mode = ocd_mode_t'({1'b0, op[5:4]});
            end
            default:              r.kind = k_illegal;
         endcase
      end
      if (r.kind == k_sp_to_idx || r.kind == k_idx_to_sp || r.kind == k_swap_d) begin
         r.total = `OCD_CYC_XFER;
      end else if (r.kind == k_zcmp_mem) begin
         r.total = `OCD_CYC_ZCMP_MEM;
      end else if (r.mode == m_imm) begin
         r.total = `OCD_CYC_IMM;
      end else if (r.mode == m_dir) begin
         r.total = `OCD_CYC_DIR;
      end else if (r.mode != m_inh) begin
         r.total = `OCD_CYC_EXT_IND;
      end
      if (r.kind == k_sub_d) begin
         r.total = r.total + `OCD_CYC_WORD_EXTRA;
      end
      // Prefix only selects Y for indexed and register transfer forms
      if (pfx) begin
         if (r.mode == m_ind || r.kind == k_sp_to_idx || r.kind == k_idx_to_sp ||
             r.kind == k_swap_d) begin
            r.total = r.total + `OCD_CYC_PREFIX;
         end else begin
            r.kind  = k_illegal;
            r.mode  = m_inh;
            r.total = `OCD_CYC_INH + `OCD_CYC_PREFIX;
         end
      end
      return r;
   endfunction

   // ---------------------------------------------
   // Sequencer
   // ---------------------------------------------
   always_comb begin
      d     = q;
      dc    = ocd_decode(q.op, q.pfx);
      go    = 1'b0;
      fin   = 1'b0;
      lhs8  = 8'h00;
      dif9  = 9'h000;
      dif17 = 17'h00000;
      d.ill = 1'b0;
      d.cyc = q.cyc + 5'd1;
      idx   = q.pfx ? q.iy : q.ix;
      wake  = (irq_i & ~q.flag_register[`OCD_F_I]) | (xirq_i & ~q.flag_register[`OCD_F_X]);
      unique case (q.st)
         st_fetch: begin
            d.op  = data_i;
            d.pfx = 1'b0;
            d.pc  = q.pc + 16'h0001;
            if (data_i == `OCD_OP_PREFIX) begin
               d.st = st_prefix;
            end else begin
               go = 1'b1;
            end
         end
         st_prefix: begin
            d.op  = data_i;
            d.pfx = 1'b1;
            d.pc  = q.pc + 16'h0001;
            go    = 1'b1;
         end
         st_operand: begin
            d.pc = q.pc + 16'h0001;
            d.st = st_data;
            d.cnt = 4'h0;
            unique case (dc.mode)
               m_dir: d.ea = {8'h00, data_i};
               m_ind: begin
                  d.ea = idx + {8'h00, data_i};
                  d.st = st_calc;
               end
               default: begin
                  if (q.cnt == 4'h0) begin
                     d.ea[15:8] = data_i;
                     d.cnt      = 4'h1;
                     d.st       = st_operand;
                  end else begin
                     d.ea[7:0] = data_i;
                  end
               end
            endcase
         end
         st_calc: d.st = st_data;
         st_data: begin
            if (dc.mode == m_imm) begin
               d.pc = q.pc + 16'h0001;
            end
            if (dc.kind == k_sub_d && q.cnt == 4'h0) begin
               d.opw[15:8] = data_i;
               d.cnt       = 4'h1;
            end else begin
               d.opw[7:0] = data_i;
               fin        = 1'b1;
            end
         end
         st_pad:      fin = 1'b1;
         st_stk_pre: begin
            d.st  = st_stack;
            d.cnt = 4'h0;
         end
         st_stack: begin
            d.sp  = q.sp - 16'h0001;
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == `OCD_PUSH_LAST) begin
               d.st = st_stk_post;
            end
         end
         st_stk_post: begin
            d.cnt = 4'h0;
            if (dc.kind == k_soft_trap) begin
               d.flag_register[`OCD_F_I] = 1'b1;
               d.vsel          = 1'b0;
               d.st            = st_vector;
            end else begin
               d.wt = 1'b1;
               d.st = st_sleep;
            end
         end
         st_sleep: begin
            if (wake) begin
               d.wt            = 1'b0;
               d.vsel          = 1'b1;
               d.flag_register[`OCD_F_I] = 1'b1;
               d.flag_register[`OCD_F_X] = q.flag_register[`OCD_F_X] | (xirq_i & ~q.flag_register[`OCD_F_X]);
               d.st            = st_vector;
            end
         end
         st_vector: begin
            if (q.cnt == 4'h0) begin
               d.pc[15:8] = data_i;
               d.cnt      = 4'h1;
            end else begin
               d.pc[7:0] = data_i;
               d.st      = st_fetch;
               d.cyc     = 5'd0;
            end
         end
         st_testrun: d.st = st_testrun;
         default:    d.st = st_fetch;
      endcase

      if (go) begin
         dc    = ocd_decode(d.op, d.pfx);
         d.cnt = 4'h0;
         d.ill = (dc.kind == k_illegal) || (dc.kind == k_test_run && !test_mode_i);
         if (dc.kind == k_test_run && test_mode_i) begin
            d.st = st_testrun;
         end else if (dc.kind == k_soft_trap || dc.kind == k_sleep) begin
            d.st = st_stk_pre;
         end else if (dc.mode == m_inh) begin
            fin = 1'b1;
         end else if (dc.mode == m_imm) begin
            d.st = st_data;
         end else begin
            d.st = st_operand;
         end
      end

      // ---------------------------------------------
      // Execute on the last cycle of the instruction
      // ---------------------------------------------
      if (fin) begin
         if (q.cyc != dc.total - 5'd1) begin
            d.st = st_pad;
         end else begin
            d.st  = st_fetch;
            d.cyc = 5'd0;
            unique case (dc.kind)
               k_sub_a, k_sub_b: begin
                  lhs8 = (dc.kind == k_sub_a) ? q.a : q.b;
                  dif9 = {1'b0, lhs8} - {1'b0, d.opw[7:0]};
                  d.flag_register[`OCD_F_N] = dif9[7];
                  d.flag_register[`OCD_F_Z] = (dif9[7:0] == 8'h00);
                  d.flag_register[`OCD_F_V] = (lhs8[7] ^ d.opw[7]) & (lhs8[7] ^ dif9[7]);
                  d.flag_register[`OCD_F_C] = dif9[8];
                  if (dc.kind == k_sub_a) begin
                     d.a = dif9[7:0];
                  end else begin
                     d.b = dif9[7:0];
                  end
               end
               k_sub_d: begin
                  dif17 = {1'b0, q.a, q.b} - {1'b0, d.opw};
                  d.flag_register[`OCD_F_N] = dif17[15];
                  d.flag_register[`OCD_F_Z] = (dif17[15:0] == 16'h0000);
                  d.flag_register[`OCD_F_V] = (q.a[7] ^ d.opw[15]) & (q.a[7] ^ dif17[15]);
                  d.flag_register[`OCD_F_C] = dif17[16];
                  {d.a, d.b}      = dif17[15:0];
               end
               k_zcmp_mem, k_zcmp_a, k_zcmp_b: begin
                  lhs8 = (dc.kind == k_zcmp_a) ? q.a :
                         (dc.kind == k_zcmp_b) ? q.b : d.opw[7:0];
                  d.flag_register[`OCD_F_N] = lhs8[7];
                  d.flag_register[`OCD_F_Z] = (lhs8 == 8'h00);
                  d.flag_register[`OCD_F_V] = 1'b0;
                  d.flag_register[`OCD_F_C] = 1'b0;
               end
               k_copy_a_b, k_copy_b_a: begin
                  lhs8 = (dc.kind == k_copy_a_b) ? q.a : q.b;
                  d.a  = lhs8;
                  d.b  = lhs8;
                  d.flag_register[`OCD_F_N] = lhs8[7];
                  d.flag_register[`OCD_F_Z] = (lhs8 == 8'h00);
                  d.flag_register[`OCD_F_V] = 1'b0;
               end
               k_flags_in:  d.flag_register = {q.a[7], q.flag_register[`OCD_F_X] & q.a[6], q.a[5:0]};
               k_flags_out: d.a = q.flag_register;
               k_sp_to_idx: begin
                  if (q.pfx) begin
                     d.iy = q.sp + 16'h0001;
                  end else begin
                     d.ix = q.sp + 16'h0001;
                  end
               end
               k_idx_to_sp: d.sp = idx - 16'h0001;
               k_swap_d: begin
                  {d.a, d.b} = idx;
                  if (q.pfx) begin
                     d.iy = {q.a, q.b};
                  end else begin
                     d.ix = {q.a, q.b};
                  end
               end
               default: d.a = q.a;
            endcase
         end
      end

      // ---------------------------------------------
      // Bus access for the coming cycle
      // ---------------------------------------------
      d.rw    = 1'b1;
      d.wdata = 8'h00;
      unique case (d.st)
         st_fetch, st_prefix, st_operand: d.addr = d.pc;
         st_data: d.addr = (dc.mode == m_imm) ? d.pc : d.ea + {15'd0, d.cnt[0]};
         st_stack: begin
            d.addr = d.sp;
            d.rw   = 1'b0;
            unique case (d.cnt)
               4'h0:    d.wdata = d.pc[7:0];
               4'h1:    d.wdata = d.pc[15:8];
               4'h2:    d.wdata = d.iy[7:0];
               4'h3:    d.wdata = d.iy[15:8];
               4'h4:    d.wdata = d.ix[7:0];
               4'h5:    d.wdata = d.ix[15:8];
               4'h6:    d.wdata = d.a;
               4'h7:    d.wdata = d.b;
               default: d.wdata = d.flag_register;
            endcase
         end
         st_vector:  d.addr = (d.vsel ? irq_vec_i : `OCD_VEC_TRAP) + {15'd0, d.cnt[0]};
         // First test cycle starts after the opcode
         st_testrun: d.addr = (q.st == st_testrun) ? q.addr + 16'h0001 : d.pc;
         default:    d.addr = `OCD_IDLE_ADDR;
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= RST_STATE;
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------
   // Outputs, all straight from the state flops
   // ---------------------------------------------
   assign addr_o          = q.addr;
   assign rw_o            = q.rw;
   assign wdata_o         = q.wdata;
   assign acc_a_o         = q.a;
   assign acc_b_o         = q.b;
   assign index_x_o       = q.ix;
   assign index_y_o       = q.iy;
   assign sp_o            = q.sp;
   assign pc_o            = q.pc;
   assign flag_register_o = q.flag_register;
   assign illegal_op_o    = q.ill;
   assign sleeping_o      = q.wt;

endmodule

`default_nettype wire

// ===== sim/ocd_core_assertions.sv
`default_nettype none

module ocd_core_assertions (
   input wire logic        sys_clk_i,
   input wire logic        rst_i,
   input wire logic        irq_i,
   input wire logic        xirq_i,
   input wire logic [15:0] irq_vec_i,
   input wire logic [15:0] addr_o,
   input wire logic        rw_o,
   input wire logic [15:0] sp_o,
   input wire logic [7:0]  flag_register_o,
   input wire logic        sleeping_o
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   property p_reset_state;
      $fell(rst_i) |-> addr_o == 16'h0000 && rw_o && flag_register_o == 8'hd0;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("bad state after reset");

   property p_push_count;
      $fell(rw_o) |-> ##8 !rw_o ##1 rw_o && addr_o == 16'hffff;
   endproperty
   a_push_count: assert property (p_push_count) else $error("push count wrong");

   property p_push_down;
      !rw_o && !$fell(rw_o) |-> addr_o == $past(addr_o) - 16'h0001;
   endproperty
   a_push_down: assert property (p_push_down) else $error("push order wrong");

   property p_after_push;
      $fell(rw_o) |-> ##10 (sleeping_o || addr_o == 16'hff00);
   endproperty
   a_after_push: assert property (p_after_push) else $error("no vector or sleep");

   property p_sleep_idle;
      sleeping_o |-> addr_o == 16'hffff && rw_o;
   endproperty
   a_sleep_idle: assert property (p_sleep_idle) else $error("bus busy in sleep");

   property p_sleep_holds;
      sleeping_o && !irq_i && !xirq_i |=> sleeping_o;
   endproperty
   a_sleep_holds: assert property (p_sleep_holds) else $error("woke without cause");

   property p_wake;
      sleeping_o && irq_i && !flag_register_o[4]
         |=> addr_o == irq_vec_i ##1 addr_o == irq_vec_i + 16'h0001;
   endproperty
   a_wake: assert property (p_wake) else $error("wake vector wrong");

   property p_x_kept;
      !flag_register_o[6] && !xirq_i |=> !flag_register_o[6];
   endproperty
   a_x_kept: assert property (p_x_kept) else $error("x mask set");

   property p_sleep_quiet;
      sleeping_o && $past(sleeping_o) |-> $stable(flag_register_o) && $stable(sp_o);
   endproperty
   a_sleep_quiet: assert property (p_sleep_quiet) else $error("state moved in sleep");
endmodule

bind ocd_core ocd_core_assertions i_ocd_core_assertions (
   .sys_clk_i, .rst_i, .irq_i, .xirq_i, .irq_vec_i, .addr_o, .rw_o, .sp_o,
   .flag_register_o, .sleeping_o
);

`default_nettype wire

// ===== sim/ocd_mem_model.sv
`default_nettype none

module ocd_mem_model (
   input  wire logic        sys_clk_i,
   input  wire logic [15:0] addr_i,
   input  wire logic        rw_i,
   input  wire logic [7:0]  wdata_i,
   output wire logic [7:0]  rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] mem [65536];

   // Filler is an undecoded opcode, so stray fetches stay harmless
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'h01;
      end
   end

   // Zero-wait read; write cycles show inverted data, never a stale byte
   assign rdata_o = rw_i ? mem[addr_i] : ~wdata_i;

   always @(posedge sys_clk_i) begin
      if (!rw_i) begin
         mem[addr_i] <= wdata_i;
      end
   end
endmodule

`default_nettype wire

// ===== sim/ocd_core_tb.sv
`default_nettype none

module ocd_core_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic        sys_clk_i, rst_i, irq_i, xirq_i, test_mode_i;
   logic [15:0] irq_vec_i, addr_o, index_x_o, index_y_o, sp_o, pc_o;
   logic [7:0]  data_i, wdata_o, acc_a_o, acc_b_o, flag_register_o;
   logic        rw_o, illegal_op_o, sleeping_o;
   int          failures, n_checks;

   ocd_core i_ocd_core (
      .sys_clk_i, .rst_i, .data_i, .irq_i, .xirq_i, .test_mode_i, .irq_vec_i,
      .addr_o, .rw_o, .wdata_o, .acc_a_o, .acc_b_o, .index_x_o, .index_y_o,
      .sp_o, .pc_o, .flag_register_o, .illegal_op_o, .sleeping_o
   );

   ocd_mem_model i_ocd_mem_model (
      .sys_clk_i, .addr_i(addr_o), .rw_i(rw_o), .wdata_i(wdata_o), .rdata_o(data_i)
   );

   initial begin
      sys_clk_i = 1'b0;
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic prog(input logic [15:0] a, input logic [175:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         i_ocd_mem_model.mem[a + 16'(i)] = v[8 * (n - 1 - i) +: 8];
      end
   endtask

   function automatic logic [7:0] m(input logic [15:0] a);
      return i_ocd_mem_model.mem[a];
   endfunction

   // Fetch at 0000 is cycle 0, starting at the releasing edge
   task automatic start(input logic tm);
      @(posedge sys_clk_i);
      rst_i <= 1'b1;
      test_mode_i <= tm;
      repeat (4) @(posedge sys_clk_i);
      rst_i <= 1'b0;
   endtask

   task automatic run(input int k);
      repeat (k) @(posedge sys_clk_i);
      #1;
   endtask

   task automatic t_acc();
      prog(16'h0000, 64'h8005165dc0fb4d17, 8);
      start(1'b0);
      run(2); chk({acc_a_o, flag_register_o}, 16'hfbd9);
      run(2); chk({acc_b_o, flag_register_o}, 16'hfbd9);
      run(2); chk(flag_register_o, 8'hd8);
      run(2); chk({acc_b_o, flag_register_o}, 16'h00d4);
      run(2); chk(flag_register_o, 8'hd8);
      run(2); chk({acc_a_o, flag_register_o, addr_o}, 32'h00d40008);
   endtask

   task automatic t_word();
      prog(16'h0000, 176'h83f0008fa0107d12349040b01235351830188f183530, 22);
      prog(16'h1010, 8'h03, 1);
      prog(16'h1234, 16'h8002, 2);
      prog(16'h0040, 8'h7f, 1);
      start(1'b0);
      run(4); chk({acc_a_o, acc_b_o, flag_register_o}, 24'h1000d1);
      run(3); chk({index_x_o, acc_a_o, acc_b_o}, 32'h10000000);
      run(4); chk({acc_a_o, flag_register_o}, 16'hfdd9);
      run(6); chk(flag_register_o, 8'hd8);
      run(3); chk({acc_a_o, flag_register_o}, 16'h7ed2);
      run(4); chk({acc_a_o, flag_register_o}, 16'h7cd0);
      run(3); chk(sp_o, 16'h0fff);
      run(4); chk(index_y_o, 16'h1000);
      run(4); chk({index_y_o, acc_a_o, acc_b_o}, 32'h7c001000);
      run(4); chk(sp_o, 16'h7bff);
      run(3); chk({index_x_o, addr_o, flag_register_o}, 40'h7c000016d0);
   endtask

   task automatic t_flags();
      prog(16'h0000, 56'h80c10680ff0607, 7);
      start(1'b0);
      run(4); chk(flag_register_o, 8'h3f);
      run(4); chk({acc_a_o, flag_register_o}, 16'h4000);
      run(2); chk({acc_a_o, flag_register_o}, 16'h0000);
   endtask

   task automatic t_sleep();
      prog(16'h0000, 32'h80f1063e, 4);
      prog(16'h2000, 16'h3000, 2);
      start(1'b0);
      run(16); chk(sleeping_o, 1'b1);
      run(5); chk({sleeping_o, addr_o}, 17'h1ffff);
      @(posedge sys_clk_i);
      irq_i <= 1'b1;
      run(3); chk({addr_o, flag_register_o, sp_o}, 40'h30001ffff7);
      chk({m(16'h0000), m(16'hfffa), m(16'hfff8)}, 24'h040f0f);
      @(posedge sys_clk_i);
      irq_i <= 1'b0;
   endtask

   task automatic t_trap();
      prog(16'h0000, 32'h80f1063f, 4);
      prog(16'hff00, 16'h4000, 2);
      start(1'b0);
      run(18); chk({addr_o, flag_register_o, sp_o}, 40'h40001ffff7);
      chk(pc_o, 16'h4000);
   endtask

   task automatic t_test();
      prog(16'h0000, 8'h00, 1);
      start(1'b1);
      run(41); chk({addr_o, flag_register_o}, 24'h0029d0);
      start(1'b0);
      run(1); chk(illegal_op_o, 1'b1);
      run(1); chk({addr_o, flag_register_o}, 24'h0001d0);
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Whole run is under two hundred cycles; fifteen times that means a hang
   initial begin
      repeat (3000) @(posedge sys_clk_i);
      failures++;
      wrap_up();
   end

   initial begin
      rst_i = 1'b1;
      irq_i = 1'b0;
      xirq_i = 1'b0;
      test_mode_i = 1'b0;
      irq_vec_i = 16'h2000;
      failures = 0;
      n_checks = 0;
      @(posedge sys_clk_i);
      t_acc();
      t_word();
      t_flags();
      t_sleep();
      t_trap();
      t_test();
      wrap_up();
   end
endmodule

`default_nettype wire
